// ---- hw/sfspi_pkg.sv ----
package sfspi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes, one byte each, shifted most significant bit first
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_DUAL_READ = 8'h3b;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry; no page erase code exists
  localparam int ARRAY_BYTES = 1048576;
  localparam int ARRAY_SECTORS = 256;
  localparam int ARRAY_BLOCKS = 16;
  localparam int ADDR_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Status reset values; protect and lock ship cleared
  localparam logic [3:0] PROT_RST = 4'h0;
  localparam logic LOCK_RST = 1'b0;
  localparam logic WEL_RST = 1'b0;
  localparam logic RSVD_VAL = 1'b0;
  localparam logic [3:0] PROT_NONE = 4'h0;

  // Shift counts
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte, bit 7 down to bit 0
  typedef struct packed {
    logic lock;
    logic rsvd;
    logic [3:0] prot;
    logic write_latch_flag;
    logic busy;
  } sfspi_status_t;

  // Pad inputs that cross into the system clock
  typedef struct packed {
    logic sck;
    logic cs_b;
    logic si;
    logic hold_b;
    logic wp_b;
  } sfspi_pins_t;

  localparam sfspi_pins_t PINS_RST = 5'h0b;

  // Interface states, Gray along command, address, dummy, dual output
  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_ADDR = 3'h1,
    ST_DUMMY = 3'h3,
    ST_DUAL = 3'h2,
    ST_DOUT = 3'h6,
    ST_DIN = 3'h7,
    ST_WAIT = 3'h5,
    ST_IGN = 3'h4
  } sfspi_state_t;

endpackage

// ---- hw/sfspi_pin_sync.sv ----
`timescale 1ns/10ps
module sfspi_pin_sync (
  input wire logic clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire sfspi_pkg::sfspi_pins_t pin_raw, // Pads, unsynchronised
  output sfspi_pkg::sfspi_pins_t pin_sync, // After two flops
  output sfspi_pkg::sfspi_pins_t pin_prev // One cycle older, for edges
);
  import sfspi_pkg::*;

  sfspi_pins_t meta_q;
  sfspi_pins_t sync_q;
  sfspi_pins_t prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser; only sync_q reads meta_q
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= PINS_RST;
      sync_q <= PINS_RST;
      prev_q <= PINS_RST;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pin_sync = sync_q;
  assign pin_prev = prev_q;

endmodule

// ---- hw/sfspi_front_end.sv ----
`timescale 1ns/10ps
// What this block does
// - Sample on SCK rise, drive on fall
// - Dual read drives both data pins
// - Dual output continues until deselect
// - Dual read ignores write-protect pin
// - Deselect during pause resets interface
// - Pause begins with SCK low
// - Pause ends with SCK low
// - Paused: outputs off, inputs ignored
// - Pause never aborts internal operation
// - Status byte field order fixed
// - Busy flag read-only; all but read status ignored while busy
// - Write latch gates program and erase
// - Write disable clears the latch
// - Latch clears on completion and reset
// - Protect bits block selected region
// - Chip erase only when unprotected
// - Protect bits default to zero
// - Reserved status bit reads zero
// - Lock bit plus pin blocks status writes
// - One megabyte array, no page erase
// - Bytes shift most significant first
// - Deselected outputs are high impedance
// - Read status returns status byte
module sfspi_front_end (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic sck, // Serial clock pad
  input wire logic cs_b, // Chip select pad, active low
  input wire logic serial_in_dual_in, // Serial input pad level
  output logic serial_in_dual_out, // Second data output in dual read
  output logic serial_in_dual_oe, // High while driving that pad
  output logic so_out, // Serial output data
  output logic so_oe, // High while driving serial output
  input wire logic wp_b, // Write protect pad, active low
  input wire logic hold_b, // Pause pad, active low
  input wire logic core_busy, // Array engine is running
  input wire logic core_done, // Pulse: operation ended well
  input wire logic [7:0] rd_data, // Array byte for last request
  output logic rd_req, // Pulse: fetch byte at op_addr
  output logic op_start, // Pulse: start program or erase
  output logic [7:0] op_code, // Command for op_start
  output logic [sfspi_pkg::ADDR_W-1:0] op_addr, // Array address
  output logic [3:0] prot_code, // Protect bits for region check
  output logic [7:0] wr_byte, // Program data byte
  output logic wr_strobe // Pulse: wr_byte valid
);
  import sfspi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command decoding helpers
  function automatic logic is_erase(input logic [7:0] op);
    return (op == OP_SECTOR_ERASE) || (op == OP_BLOCK_ERASE);
  endfunction

  // Page erase is deliberately absent from this decode
  function automatic sfspi_state_t cmd_next(input logic [7:0] op,
                                            input logic busy);
    sfspi_state_t nxt;
    nxt = ST_IGN;
    if (!busy || (op == OP_READ_STATUS)) begin
      unique case (op)
        OP_READ_STATUS: nxt = ST_DOUT;
        OP_READ, OP_FAST_READ, OP_DUAL_READ, OP_PROGRAM,
        OP_SECTOR_ERASE, OP_BLOCK_ERASE: nxt = ST_ADDR;
        OP_WRITE_STATUS: nxt = ST_DIN;
        OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_CHIP_ERASE: nxt = ST_WAIT;
        default: nxt = ST_IGN;
      endcase
    end
    return nxt;
  endfunction

  function automatic sfspi_state_t after_addr(input logic [7:0] op);
    sfspi_state_t nxt;
    nxt = ST_WAIT;
    if (op == OP_READ) begin
      nxt = ST_DOUT;
    end else if ((op == OP_FAST_READ) || (op == OP_DUAL_READ)) begin
      nxt = ST_DUMMY;
    end else if (op == OP_PROGRAM) begin
      nxt = ST_DIN;
    end
    return nxt;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pads into the clock domain and edge finding
  sfspi_pins_t pin_raw;
  sfspi_pins_t pin_s;
  sfspi_pins_t pin_p;

  assign pin_raw = '{sck: sck, cs_b: cs_b, si: serial_in_dual_in,
                     hold_b: hold_b, wp_b: wp_b};

  sfspi_pin_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_raw(pin_raw),
    .pin_sync(pin_s),
    .pin_prev(pin_p)
  );

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  assign sck_rise = pin_s.sck & ~pin_p.sck;
  assign sck_fall = ~pin_s.sck & pin_p.sck;
  assign cs_rise = pin_s.cs_b & ~pin_p.cs_b;

  ////////////////////////////////////////////////////////////////////////////
  // Pause tracking: the pad only counts while SCK is low and selected
  logic hold_q;
  logic hold_d;
  logic active;
  logic rise_ok;
  logic fall_ok;

  // A deselect keeps the pause until hold_b is high with CS low
  assign hold_d = (~pin_s.sck & ~pin_s.cs_b) ? ~pin_s.hold_b : hold_q;
  assign active = ~hold_q & ~pin_s.cs_b;
  assign rise_ok = sck_rise & active;
  assign fall_ok = sck_fall & active;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shifter, most significant bit first
  logic [2:0] bit_cnt_q;
  logic [6:0] in_sr_q;
  logic [7:0] byte_in;
  logic byte_done;

  assign byte_in = {in_sr_q, pin_s.si};
  assign byte_done = rise_ok & (bit_cnt_q == SINGLE_LAST);

  // Counter resets on any deselect, including one during a pause
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= 3'h0;
      in_sr_q <= 7'h00;
    end else if (pin_s.cs_b) begin
      bit_cnt_q <= 3'h0;
    end else if (rise_ok) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      in_sr_q <= byte_in[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interface state machine
  logic [7:0] op_q;
  logic [1:0] addr_cnt_q;
  sfspi_state_t state_q;
  sfspi_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (pin_s.cs_b) begin
      state_d = ST_CMD;
    end else if (byte_done) begin
      unique case (state_q)
        ST_CMD: state_d = cmd_next(byte_in, core_busy);
        ST_ADDR: begin
          if (addr_cnt_q == ADDR_LAST) begin
            state_d = after_addr(op_q);
          end
        end
        ST_DUMMY: state_d = (op_q == OP_DUAL_READ) ? ST_DUAL : ST_DOUT;
        ST_WAIT: state_d = ST_IGN;
        ST_DUAL, ST_DOUT, ST_DIN, ST_IGN: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_CMD;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command, address and data byte capture
  logic [23:0] addr_q;
  logic load;
  logic got_q;
  logic [7:0] wsr_q;
  logic rd_req_q;
  logic wr_strobe_q;
  logic [7:0] wr_byte_q;
  logic start_rd;

  assign start_rd = byte_done & ((state_q == ST_ADDR) |
                    (state_q == ST_DUMMY)) &
                    ((state_d == ST_DOUT) | (state_d == ST_DUAL));

  // Address advances the cycle after each request is shown
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= 8'h00;
      addr_cnt_q <= 2'h0;
      addr_q <= 24'h000000;
      got_q <= 1'b0;
      wsr_q <= 8'h00;
    end else if (pin_s.cs_b) begin
      addr_cnt_q <= 2'h0;
      got_q <= 1'b0;
    end else begin
      if (byte_done && (state_q == ST_CMD)) begin
        op_q <= byte_in;
      end
      if (byte_done && (state_q == ST_ADDR)) begin
        addr_cnt_q <= addr_cnt_q + 2'h1;
        addr_q <= {addr_q[15:0], byte_in};
      end else if (rd_req_q) begin
        addr_q <= addr_q + 24'h000001;
      end
      if (byte_done && (state_q == ST_DIN) && !got_q) begin
        got_q <= 1'b1;
        wsr_q <= byte_in;
      end
    end
  end

  // Program bytes stream to the engine as they arrive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_strobe_q <= 1'b0;
      wr_byte_q <= 8'h00;
      rd_req_q <= 1'b0;
    end else begin
      wr_strobe_q <= byte_done & (state_q == ST_DIN) & (op_q == OP_PROGRAM);
      wr_byte_q <= byte_done ? byte_in : wr_byte_q;
      rd_req_q <= start_rd | (load & (op_q != OP_READ_STATUS));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register
  logic wel_q;
  logic lock_q;
  logic [3:0] prot_q;
  sfspi_status_t status;

  assign status = '{lock: lock_q, rsvd: RSVD_VAL, prot: prot_q,
                    write_latch_flag: wel_q, busy: core_busy};

  ////////////////////////////////////////////////////////////////////////////
  // Execution at a byte-aligned deselect
  logic exec;
  logic write_enable_cmd_exec;
  logic write_disable_cmd_exec;
  logic wsr_exec;
  logic core_exec;
  logic op_start_q;

  // A deselect while paused only resets, it never executes
  assign exec = cs_rise & ~hold_q & (bit_cnt_q == 3'h0);
  assign write_enable_cmd_exec = exec & (state_q == ST_WAIT) &
                     (op_q == OP_WRITE_ENABLE);
  assign write_disable_cmd_exec = exec & (state_q == ST_WAIT) &
                     (op_q == OP_WRITE_DISABLE);
  // Write-protect is sampled only here, so dual reads never see it
  assign wsr_exec = exec & (state_q == ST_DIN) & got_q & wel_q &
                    (op_q == OP_WRITE_STATUS) &
                    ~(lock_q & ~pin_s.wp_b);
  assign core_exec = exec & wel_q & (((state_q == ST_WAIT) &
                     (is_erase(op_q) | ((op_q == OP_CHIP_ERASE) &
                     (prot_q == PROT_NONE)))) |
                     ((state_q == ST_DIN) & got_q &
                     (op_q == OP_PROGRAM)));

  // Clears first so a write-enable in the same cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wel_q <= WEL_RST;
      lock_q <= LOCK_RST;
      prot_q <= PROT_RST;
      op_start_q <= 1'b0;
    end else begin
      if (write_disable_cmd_exec || wsr_exec || core_done) begin
        wel_q <= 1'b0;
      end
      if (write_enable_cmd_exec) begin
        wel_q <= 1'b1;
      end
      if (wsr_exec) begin
        lock_q <= wsr_q[7];
        prot_q <= wsr_q[5:2];
      end
      // Pause state never reaches the engine's run or done
      op_start_q <= core_exec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter, updated on SCK falls
  logic out_mode;
  logic dual_mode;
  logic [7:0] out_src;
  logic [7:0] out_cur;
  logic [2:0] ocnt_q;
  logic [7:0] osr_q;
  logic so_q;
  logic io0_q;
  logic drv_q;

  assign out_mode = (state_q == ST_DOUT) | (state_q == ST_DUAL);
  assign dual_mode = state_q == ST_DUAL;
  // Status is resampled at each byte, so busy can be polled
  assign out_src = (op_q == OP_READ_STATUS) ? status : rd_data;
  assign out_cur = (ocnt_q == 3'h0) ? out_src : osr_q;
  assign load = fall_ok & out_mode & (ocnt_q == 3'h0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ocnt_q <= 3'h0;
      osr_q <= 8'h00;
      so_q <= 1'b0;
      io0_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (pin_s.cs_b) begin
      ocnt_q <= 3'h0;
      drv_q <= 1'b0;
    end else if (fall_ok && out_mode) begin
      so_q <= out_cur[7];
      io0_q <= out_cur[6];
      osr_q <= dual_mode ? {out_cur[5:0], 2'b00} : {out_cur[6:0], 1'b0};
      ocnt_q <= load ? (dual_mode ? DUAL_LAST : SINGLE_LAST)
                     : ocnt_q - 3'h1;
      drv_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pads and engine outputs
  assign so_out = so_q;
  assign so_oe = out_mode & drv_q & active;
  assign serial_in_dual_out = io0_q;
  assign serial_in_dual_oe = dual_mode & drv_q & active;
  assign rd_req = rd_req_q;
  assign op_start = op_start_q;
  assign op_code = op_q;
  assign op_addr = addr_q[ADDR_W-1:0];
  assign prot_code = prot_q;
  assign wr_byte = wr_byte_q;
  assign wr_strobe = wr_strobe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RISE_ONLY: assert property (
    !rise_ok |=> (bit_cnt_q == $past(bit_cnt_q)) || $past(pin_s.cs_b))
    else $error("bit counter moved without an SCK rise");
  AST_DUAL_NIBBLE: assert property (
    (load && dual_mode) |=> ocnt_q == 3'h3)
    else $error("dual byte not four falls long");
  AST_DUAL_STAYS: assert property (
    (state_q == ST_DUAL && !pin_s.cs_b) |=> state_q == ST_DUAL)
    else $error("dual output left while selected");
  AST_DESEL_RESET: assert property (
    pin_s.cs_b |=> (state_q == ST_CMD) && (bit_cnt_q == 3'h0))
    else $error("deselect did not reset the interface");
  AST_HOLD_KEEP: assert property (
    (hold_q && pin_s.cs_b) |=> hold_q)
    else $error("pause released while deselected");
  AST_HOLD_ENTER: assert property (
    (!pin_s.hold_b && !pin_s.sck && !pin_s.cs_b) |=> hold_q)
    else $error("pause not entered with SCK low");
  AST_HOLD_SCK_HIGH: assert property (
    (!hold_q && pin_s.sck) |=> !hold_q)
    else $error("pause entered while SCK high");
  AST_HOLD_EXIT: assert property (
    (hold_q && pin_s.hold_b && !pin_s.sck && !pin_s.cs_b) |=> !hold_q)
    else $error("pause not ended with SCK low");
  AST_HOLD_HIZ: assert property (
    hold_q |-> !so_oe && !serial_in_dual_oe)
    else $error("output driven while paused");
  AST_BUSY_IGNORE: assert property (
    (byte_done && state_q == ST_CMD && core_busy &&
     byte_in != OP_READ_STATUS) |=> state_q == ST_IGN)
    else $error("command taken while busy");
  AST_WEL_NEEDED: assert property (
    op_start |-> $past(wel_q))
    else $error("operation started without write latch");
  AST_WEL_DISABLE: assert property (
    write_disable_cmd_exec |=> !wel_q)
    else $error("write disable left latch set");
  AST_WEL_DONE: assert property (
    (core_done && !write_enable_cmd_exec) |=> !wel_q)
    else $error("latch not cleared on completion");
  AST_CHIP_PROT: assert property (
    (op_start && op_code == OP_CHIP_ERASE) |-> $past(prot_q) == 4'h0)
    else $error("chip erase started while protected");
  AST_RSVD_ZERO: assert property (
    (load && op_q == OP_READ_STATUS && !dual_mode) |=> osr_q[7] == 1'b0)
    else $error("reserved status bit not zero");
  AST_LOCKED: assert property (
    (exec && lock_q && !pin_s.wp_b) |=> $stable(prot_q) && $stable(lock_q))
    else $error("locked status register was written");
  AST_DESEL_HIZ: assert property (
    $past(pin_s.cs_b) |-> !so_oe && !serial_in_dual_oe)
    else $error("output driven while deselected");

  COV_DUAL: cover property (load && dual_mode);
  COV_HOLD: cover property (out_mode && hold_q ##1 !hold_q);
  COV_POLL: cover property (load && op_q == OP_READ_STATUS && core_busy);
  COV_ERASE: cover property (op_start && op_code == OP_CHIP_ERASE);

endmodule

// ---- tb/sfspi_host_model.sv ----
`timescale 1ns/10ps
module sfspi_host_model (
  input wire logic clk, // Paces the link
  input wire logic so_w, // Serial output wire level
  input wire logic io0_w, // Second data wire level
  output logic sck, // Link clock
  output logic cs_b, // Select, active low
  output logic si, // Host data out
  output logic hold_b // Pause, active low
);
  logic cpol; // Idle clock level: mode 0 or 3

  // Deselected and idle from time zero
  initial begin
    cpol = 1'b0;
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    hold_b = 1'b1;
  end

  ////////////////////////////////////////
  // Half a link period is four system clocks
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // Clock parked at idle before select
  task automatic sel();
    sck = cpol;
    half();
    cs_b = 1'b0;
    half();
  endtask

  // Clock back to idle, then release the device
  task automatic desel();
    half();
    sck = cpol;
    half();
    cs_b = 1'b1;
    si = ~si; // Released line keeps no stale level
    repeat (2) half();
  endtask

  // Sample before the rise; dual mode toggles si each bit instead of sending tx
  task automatic xfer(input logic [7:0] tx, input logic dual,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      sck = 1'b0;
      si = dual ? ~si : tx[7-i];
      half();
      if (dual) rx[7-2*i -: 2] = {so_w, io0_w};
      else rx[7-i] = so_w;
      sck = 1'b1;
      half();
    end
  endtask

  ////////////////////////////////////////
  // Pause entered with the clock high; clock and data keep moving
  task automatic hold_on();
    hold_b = 1'b0;
    repeat (2) begin
      half();
      sck = ~sck;
      si = ~si;
    end
    half();
  endtask

  // Leave the pause, optionally deselecting first
  task automatic hold_off(input logic drop);
    if (drop) cs_b = 1'b1;
    half();
    hold_b = 1'b1;
    half();
  endtask
endmodule

// ---- tb/tb_serial_flash_spi_front_end.sv ----
`timescale 1ns/10ps
module tb_serial_flash_spi_front_end;
  import sfspi_pkg::*;
  logic clk, rst_b, wp_b, core_busy, core_done;
  logic so_last = 1'b0;
  logic sck, cs_b, si_h, hold_b, io0_out, io0_oe, so_out, so_oe;
  logic rd_req, op_start, wr_strobe;
  logic [7:0] rd_data, op_code, wr_byte;
  logic [ADDR_W-1:0] op_addr;
  logic [3:0] prot_code;
  int failures = 0;
  int total_checks = 0;
  int n_start = 0;
  int n_rd = 0;
  int n_wr = 0;

  // Undriven output shows the inverse of its last bit
  wire so_w = so_oe ? so_out : ~so_last;
  wire io0_w = io0_oe ? io0_out : si_h;

  sfspi_front_end i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .sck(sck),
    .cs_b(cs_b),
    .serial_in_dual_in(io0_w),
    .serial_in_dual_out(io0_out),
    .serial_in_dual_oe(io0_oe),
    .so_out(so_out),
    .so_oe(so_oe),
    .wp_b(wp_b),
    .hold_b(hold_b),
    .core_busy(core_busy),
    .core_done(core_done),
    .rd_data(rd_data),
    .rd_req(rd_req),
    .op_start(op_start),
    .op_code(op_code),
    .op_addr(op_addr),
    .prot_code(prot_code),
    .wr_byte(wr_byte),
    .wr_strobe(wr_strobe)
  );

  sfspi_host_model i_host (
    .clk(clk),
    .so_w(so_w),
    .io0_w(io0_w),
    .sck(sck),
    .cs_b(cs_b),
    .si(si_h),
    .hold_b(hold_b)
  );

  // Last driven bit and count of engine starts
  always @(posedge clk) begin
    if (so_oe === 1'b1) so_last <= so_out;
    if (op_start === 1'b1) n_start <= n_start + 1;
    if (rd_req === 1'b1) n_rd <= n_rd + 1;
    if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic chk_val(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One-byte command in its own frame
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(op, 1'b0, r);
    i_host.desel();
  endtask

  task automatic wrsr(input logic [7:0] d);
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(OP_WRITE_STATUS, 1'b0, r);
    i_host.xfer(d, 1'b0, r);
    i_host.desel();
  endtask

  // Status read twice in one frame to see it repeat
  task automatic rdsr(input logic [7:0] exp);
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(OP_READ_STATUS, 1'b0, r);
    repeat (2) begin
      i_host.xfer(8'h00, 1'b0, r);
      chk_val("status", exp, r);
    end
    i_host.desel();
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    chk_bit("so_oe", 1'b0, so_oe);
    chk_bit("io0_oe", 1'b0, io0_oe);
    rdsr(8'h00);
  endtask

  task automatic t_latch();
    cmd(OP_WRITE_ENABLE);
    rdsr(8'h02);
    cmd(OP_WRITE_DISABLE);
    rdsr(8'h00);
  endtask

  // Protect set, chip erase refused, lock with pin low refuses
  task automatic t_protect();
    cmd(OP_WRITE_ENABLE);
    wrsr(8'hfc);
    rdsr(8'hbc);
    chk_val("prot_code", 8'h0f, {4'h0, prot_code});
    cmd(OP_WRITE_ENABLE);
    cmd(OP_CHIP_ERASE);
    chk_val("starts", 8'h00, n_start[7:0]);
    wp_b = 1'b0;
    wrsr(8'h00);
    rdsr(8'hbe);
    wp_b = 1'b1;
    wrsr(8'h00);
    rdsr(8'h00);
  endtask

  task automatic t_busy();
    cmd(OP_CHIP_ERASE);
    chk_val("starts", 8'h00, n_start[7:0]);
    cmd(OP_WRITE_ENABLE);
    cmd(OP_CHIP_ERASE);
    chk_val("starts", 8'h01, n_start[7:0]);
    chk_val("op_code", OP_CHIP_ERASE, op_code);
    core_busy = 1'b1;
    cmd(OP_WRITE_DISABLE);
    rdsr(8'h03);
    core_busy = 1'b0;
    core_done = 1'b1;
    @(negedge clk);
    core_done = 1'b0;
    rdsr(8'h00);
  endtask

  // Pin low must not matter during the dual read
  task automatic t_dual();
    logic [7:0] r;
    wp_b = 1'b0;
    rd_data = 8'h96;
    i_host.sel();
    i_host.xfer(OP_DUAL_READ, 1'b0, r);
    repeat (4) i_host.xfer(8'h00, 1'b0, r);
    repeat (2) begin
      i_host.xfer(8'h00, 1'b1, r);
      chk_val("dual byte", 8'h96, r);
      chk_bit("io0_oe", 1'b1, io0_oe);
    end
    i_host.desel();
    chk_bit("io0_oe", 1'b0, io0_oe);
    chk_val("fetches", 8'h04, n_rd[7:0]);
    chk_val("dual addr", 8'h04, op_addr[7:0]);
    wp_b = 1'b1;
  endtask

  // Single-line reads, plain and with a dummy byte
  task automatic t_read();
    logic [7:0] r;
    rd_data = 8'ha5;
    i_host.sel();
    i_host.xfer(OP_READ, 1'b0, r);
    repeat (4) i_host.xfer(8'h00, 1'b0, r);
    chk_val("read byte", 8'ha5, r);
    i_host.desel();
    i_host.sel();
    i_host.xfer(OP_FAST_READ, 1'b0, r);
    repeat (5) i_host.xfer(8'h00, 1'b0, r);
    chk_val("fast byte", 8'ha5, r);
    i_host.desel();
  endtask

  // Latch still set from the program frame, so both erases start
  task automatic t_erase();
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(OP_SECTOR_ERASE, 1'b0, r);
    repeat (3) i_host.xfer(8'h00, 1'b0, r);
    i_host.desel();
    chk_val("starts", 8'h03, n_start[7:0]);
    chk_val("op_code", OP_SECTOR_ERASE, op_code);
    i_host.sel();
    i_host.xfer(OP_BLOCK_ERASE, 1'b0, r);
    repeat (3) i_host.xfer(8'h00, 1'b0, r);
    i_host.desel();
    chk_val("starts", 8'h04, n_start[7:0]);
    chk_val("op_code", OP_BLOCK_ERASE, op_code);
  endtask

  // Top address nibble falls outside the array
  task automatic t_program();
    logic [7:0] r;
    cmd(OP_WRITE_ENABLE);
    i_host.sel();
    i_host.xfer(OP_PROGRAM, 1'b0, r);
    i_host.xfer(8'hf1, 1'b0, r);
    i_host.xfer(8'h23, 1'b0, r);
    i_host.xfer(8'h45, 1'b0, r);
    i_host.xfer(8'h5a, 1'b0, r);
    chk_val("wr_byte", 8'h5a, wr_byte);
    i_host.desel();
    chk_val("op_code", OP_PROGRAM, op_code);
    chk_val("addr low", 8'h45, op_addr[7:0]);
    chk_val("addr high", 8'h12, op_addr[19:12]);
    chk_val("starts", 8'h02, n_start[7:0]);
    chk_val("strobes", 8'h01, n_wr[7:0]);
  endtask

  // Extra clock rises inside a pause would spoil the byte count
  task automatic t_hold();
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(OP_READ_STATUS, 1'b0, r);
    i_host.xfer(8'h00, 1'b0, r);
    chk_bit("so_oe", 1'b1, so_oe);
    i_host.hold_on();
    chk_bit("so_oe", 1'b0, so_oe);
    i_host.hold_off(1'b1);
    rdsr(8'h02);
    wp_b = 1'b0;
    i_host.sel();
    i_host.xfer(OP_WRITE_STATUS, 1'b0, r);
    i_host.hold_on();
    i_host.hold_off(1'b0);
    i_host.xfer(8'h0c, 1'b0, r);
    i_host.desel();
    wp_b = 1'b1;
    rdsr(8'h0c);
  endtask

  task automatic t_mode3();
    i_host.cpol = 1'b1;
    rdsr(8'h0c);
    i_host.cpol = 1'b0;
  endtask

  ////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    core_busy = 1'b0;
    core_done = 1'b0;
    rd_data = 8'h00;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_latch();
    t_protect();
    t_busy();
    t_dual();
    t_program();
    t_read();
    t_erase();
    t_hold();
    t_mode3();
    conclude();
  end

  // Whole run needs well under half of this span
  initial begin
    #1000000;
    failures++;
    conclude();
  end
endmodule
